// ### ctd_consts.svh
// constants for the transfer and arithmetic datapath
// Overview of operation
// - accumulator plus seven byte general registers
// - register pairs form wide accumulator and pointers
// - status word holds carry, half-carry, zero, gate
// - each flag kept, forced, computed or reloaded
// - clock counts measured in selected cpu clocks
// - pairs reachable as high and low bytes
// - branch offset is signed, added to counter
// - absolute address is sixteen-bit immediate word
// - memory operand from immediate or register address
// - byte move via third pair plus offset
// - byte swap via third pair plus offset
// - word moves and swaps reject accumulator pair
// - add absolute memory byte, flags from result
// - add immediate into short-direct memory location
// - add immediate with carry into accumulator
// - add third pair memory byte with carry
// - subtract third pair offset memory, borrow carry
`ifndef CTD_CONSTS_SVH
`define CTD_CONSTS_SVH
`define CTD_REG_CTRL    8'h00
`define CTD_REG_INSTR   8'h04
`define CTD_REG_PSW     8'h08
`define CTD_REG_PC      8'h0C
`define CTD_REG_CLKSEL  8'h10
`define CTD_REG_GPRLO   8'h14
`define CTD_REG_GPRHI   8'h18
`define CTD_CTRL_START  0
`define CTD_CTRL_BUSY   0
`define CTD_CTRL_BAD    1
`define CTD_PSW_IE      7
`define CTD_PSW_Z       6
`define CTD_PSW_AC      4
`define CTD_PSW_CY      0
`define CTD_PSW_RST     8'h00
`define CTD_PC_RST      16'h0000
`define CTD_CLKSEL_RST  2'h0
`define CTD_GPR_RST     8'h00
`define CTD_IDX_X       3'h0
`define CTD_IDX_A       3'h1
`define CTD_IDX_L       3'h6
`define CTD_IDX_H       3'h7
`define CTD_PAIR_AX     2'h0
`define CTD_OP_COUNT    8'h17
`define CTD_SADDR_SPLIT 8'h20
`define CTD_SADDR_LOW   8'hFE
`define CTD_SADDR_HIGH  8'hFF
// timing pairs: {length in bytes, clocks}
`define CTD_TM_3_6      6'h36
`define CTD_TM_2_4      6'h24
`define CTD_TM_3_8      6'h38
`define CTD_TM_2_6      6'h26
`define CTD_TM_2_8      6'h28
`define CTD_TM_1_4      6'h14
`define CTD_TM_1_8      6'h18
`define CTD_TM_1_6      6'h16
`endif

// ### ctd_pkg.sv
// types shared by the datapath modules
package ctd_pkg;
	typedef logic [7:0] ctd_byte_t;
	typedef logic [15:0] ctd_word_t;
	typedef enum logic [4:0] {
		OP_MOV_R_IMM, OP_MOV_A_R, OP_MOV_R_A, OP_MOV_A_ABS, OP_MOV_ABS_A,
		OP_MOV_PSW_IMM, OP_MOV_A_PSW, OP_MOV_PSW_A, OP_MOV_A_HLB, OP_MOV_HLB_A,
		OP_XCH_A_R, OP_XCH_A_HLB, OP_TRANSFER_WORD_AX_RP, OP_TRANSFER_WORD_RP_AX, OP_SWAP_WORD,
		OP_ADD_A_IMM, OP_ADD_A_ABS, OP_ADD_SADDR_IMM, OP_ADD_WITH_CARRY_A_IMM,
		OP_ADD_WITH_CARRY_A_HL, OP_SUB_A_HLB, OP_SUB_A_IMM, OP_BR_REL
	} ctd_op_e;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RD_REQ, ST_RD_DATA, ST_EXEC, ST_HOLD
	} ctd_state_e;
	typedef struct packed {
		logic [1:0] len;
		logic [3:0] clocks;
	} ctd_timing_s;
endpackage

// ### ctd_gpr_if.sv
// general register bank connection
`timescale 1ns/1ps
interface ctd_gpr_if;
	logic [7:0]      we;
	logic [7:0][7:0] wdata;
	logic [7:0][7:0] rdata;
	modport core (output we, output wdata, input rdata);
	modport bank (input we, input wdata, output rdata);
endinterface

// ### ctd_gpr_bank.sv
// eight byte general registers, byte-wise writable
`timescale 1ns/1ps
`include "ctd_consts.svh"
module ctd_gpr_bank (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// register access
	ctd_gpr_if.bank   gpr
);
	import ctd_pkg::*;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_reg
			always_ff @(posedge clk_i) begin
				if (rst_i)
					gpr.rdata[i] <= `CTD_GPR_RST;
				else if (gpr.we[i])
					gpr.rdata[i] <= gpr.wdata[i];
			end
		end
	endgenerate
endmodule

// ### ctd_core.sv
// transfer and arithmetic datapath with wishbone control
`timescale 1ns/1ps
`include "ctd_consts.svh"
module ctd_core (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// memory and special register port
	output ctd_pkg::ctd_word_t     mem_addr_o,
	output ctd_pkg::ctd_byte_t     mem_wdata_o,
	output logic                   mem_re_o,
	output logic                   mem_we_o,
	input  wire ctd_pkg::ctd_byte_t mem_rdata_i
);
	import ctd_pkg::*;

	ctd_gpr_if gpr ();
	ctd_gpr_bank u_bank (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.gpr   (gpr)
	);

	ctd_state_e  state;
	ctd_op_e     op;
	ctd_byte_t   status_word;
	ctd_byte_t   md;
	ctd_word_t   pc;
	logic [23:0] instr;
	logic [1:0]  cpu_clock_select_reg;
	logic [2:0]  div_cnt;
	logic [3:0]  tick_cnt;
	logic        bad;
	ctd_timing_s tm;

	// wishbone decode; writes land on the acknowledging edge
	wire        wb_req    = wb_cyc_i & wb_stb_i;
	wire        wb_wr     = wb_req & wb_we_i & wb_ack_o;
	wire        idle      = (state == ST_IDLE);
	wire [31:0] wb_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wb_merged_instr = ({8'h00, instr} & ~wb_mask) | (wb_dat_i & wb_mask);
	wire        wr_ctrl   = wb_wr & (wb_adr_i == `CTD_REG_CTRL) & wb_sel_i[0];
	wire        wr_instr  = wb_wr & (wb_adr_i == `CTD_REG_INSTR) & idle;
	wire        wr_psw    = wb_wr & (wb_adr_i == `CTD_REG_PSW) & wb_sel_i[0] & idle;
	wire        wr_pc     = wb_wr & (wb_adr_i == `CTD_REG_PC) & idle;
	wire        wr_clksel = wb_wr & (wb_adr_i == `CTD_REG_CLKSEL) & wb_sel_i[0] & idle;
	wire        start_req = wr_ctrl & wb_dat_i[`CTD_CTRL_START] & idle;
	wire [31:0] pc_merged = ({16'h0000, pc} & ~wb_mask) | (wb_dat_i & wb_mask);

	wire [31:0] rd_word =
		(wb_adr_i == `CTD_REG_CTRL)   ? {30'h0, bad, ~idle} :
		(wb_adr_i == `CTD_REG_INSTR)  ? {8'h00, instr} :
		(wb_adr_i == `CTD_REG_PSW)    ? {24'h0, status_word} :
		(wb_adr_i == `CTD_REG_PC)     ? {16'h0000, pc} :
		(wb_adr_i == `CTD_REG_CLKSEL) ? {30'h0, cpu_clock_select_reg} :
		(wb_adr_i == `CTD_REG_GPRLO)  ? gpr.rdata[3:0] :
		(wb_adr_i == `CTD_REG_GPRHI)  ? gpr.rdata[7:4] : 32'h0000_0000;

	// instruction fields: own opcode numbering, operand bytes after it
	wire [7:0] op_code = instr[7:0];
	wire [7:0] opnd_lo = instr[15:8];
	wire [7:0] opnd_hi = instr[23:16];
	wire       op_known = (op_code < `CTD_OP_COUNT);
	ctd_op_e   op_dec;
	assign op_dec = ctd_op_e'(op_code[4:0]);
	wire [2:0] sel_r  = opnd_lo[2:0];
	wire [1:0] sel_rp = opnd_lo[1:0];
	wire [2:0] sel_lo = {sel_rp, 1'b0};
	wire [2:0] sel_hi = {sel_rp, 1'b1};
	wire       is_word_op = (op_dec == OP_TRANSFER_WORD_AX_RP) | (op_dec == OP_TRANSFER_WORD_RP_AX)
	                      | (op_dec == OP_SWAP_WORD);
	wire       bad_form = ~op_known
		| (((op_dec == OP_MOV_A_R) | (op_dec == OP_MOV_R_A)) & (sel_r == `CTD_IDX_A))
		| ((op_dec == OP_XCH_A_R) & ((sel_r == `CTD_IDX_A) | (sel_r == `CTD_IDX_X)))
		| (is_word_op & (sel_rp == `CTD_PAIR_AX));

	// addressing forms
	wire [7:0]  acc     = gpr.rdata[`CTD_IDX_A];
	wire [15:0] hl      = {gpr.rdata[`CTD_IDX_H], gpr.rdata[`CTD_IDX_L]};
	wire [15:0] hl_off  = hl + {8'h00, opnd_lo};
	wire [15:0] abs_adr = {opnd_hi, opnd_lo};
	wire [15:0] saddr   = (opnd_lo < `CTD_SADDR_SPLIT) ? {`CTD_SADDR_HIGH, opnd_lo}
	                                                  : {`CTD_SADDR_LOW, opnd_lo};
	logic [15:0] next_addr;
	logic        needs_rd;
	always_comb begin
		next_addr = hl;
		needs_rd  = 1'b0;
		case (op_dec)
			OP_MOV_A_ABS, OP_ADD_A_ABS: begin
				next_addr = abs_adr;
				needs_rd  = 1'b1;
			end
			OP_MOV_ABS_A: next_addr = abs_adr;
			OP_MOV_A_HLB, OP_XCH_A_HLB, OP_SUB_A_HLB: begin
				next_addr = hl_off;
				needs_rd  = 1'b1;
			end
			OP_MOV_HLB_A: next_addr = hl_off;
			OP_ADD_SADDR_IMM: begin
				next_addr = saddr;
				needs_rd  = 1'b1;
			end
			OP_ADD_WITH_CARRY_A_HL: needs_rd = 1'b1;
			default: next_addr = hl;
		endcase
	end

	// length and clock count per instruction
	always_comb begin
		case (op)
			OP_MOV_R_IMM, OP_MOV_PSW_IMM, OP_ADD_SADDR_IMM: tm = `CTD_TM_3_6;
			OP_MOV_A_ABS, OP_MOV_ABS_A, OP_ADD_A_ABS:       tm = `CTD_TM_3_8;
			OP_MOV_A_HLB, OP_MOV_HLB_A, OP_SUB_A_HLB:       tm = `CTD_TM_2_6;
			OP_XCH_A_R, OP_BR_REL:                          tm = `CTD_TM_2_6;
			OP_XCH_A_HLB:                                   tm = `CTD_TM_2_8;
			OP_TRANSFER_WORD_AX_RP, OP_TRANSFER_WORD_RP_AX:                   tm = `CTD_TM_1_4;
			OP_SWAP_WORD:                                        tm = `CTD_TM_1_8;
			OP_ADD_WITH_CARRY_A_HL:                                   tm = `CTD_TM_1_6;
			default:                                        tm = `CTD_TM_2_4;
		endcase
	end

	// byte adder and subtractor with half-carry
	wire       use_md   = (op == OP_ADD_A_ABS) | (op == OP_ADD_WITH_CARRY_A_HL) | (op == OP_SUB_A_HLB);
	wire       is_sub   = (op == OP_SUB_A_HLB) | (op == OP_SUB_A_IMM);
	wire       alu_cin  = ((op == OP_ADD_WITH_CARRY_A_IMM) | (op == OP_ADD_WITH_CARRY_A_HL))
	                    & status_word[`CTD_PSW_CY];
	wire [7:0] alu_a    = (op == OP_ADD_SADDR_IMM) ? md : acc;
	wire [7:0] alu_b    = (op == OP_ADD_SADDR_IMM) ? opnd_hi : (use_md ? md : opnd_lo);
	wire [8:0] add_full = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
	wire [4:0] add_half = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
	wire [8:0] sub_full = {1'b0, alu_a} - {1'b0, alu_b};
	wire [4:0] sub_half = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]};
	wire [7:0] alu_res  = is_sub ? sub_full[7:0] : add_full[7:0];
	wire       alu_cy   = is_sub ? sub_full[8] : add_full[8];
	wire       alu_ac   = is_sub ? sub_half[4] : add_half[4];
	wire       is_arith = (op == OP_ADD_A_IMM) | (op == OP_ADD_A_ABS) | (op == OP_ADD_WITH_CARRY_A_IMM)
	                    | (op == OP_ADD_WITH_CARRY_A_HL) | is_sub;

	// execution: register, status and memory updates
	logic [7:0]  next_psw;
	logic [15:0] next_pc;
	logic        next_mem_we;
	logic [7:0]  next_mem_wdata;
	wire  [15:0] pc_step = pc + {14'h0, tm.len};
	wire  [15:0] br_off  = {{8{opnd_lo[7]}}, opnd_lo};
	wire         exec    = (state == ST_EXEC);
	always_comb begin
		gpr.we         = 8'h00;
		gpr.wdata      = gpr.rdata;
		next_psw       = status_word;
		next_pc        = pc_step;
		next_mem_we    = 1'b0;
		next_mem_wdata = acc;
		case (op)
			OP_MOV_R_IMM: begin
				gpr.we[sel_r]    = exec;
				gpr.wdata[sel_r] = opnd_hi;
			end
			OP_MOV_A_R: begin
				gpr.we[`CTD_IDX_A]    = exec;
				gpr.wdata[`CTD_IDX_A] = gpr.rdata[sel_r];
			end
			OP_MOV_R_A: begin
				gpr.we[sel_r]    = exec;
				gpr.wdata[sel_r] = acc;
			end
			OP_MOV_A_ABS, OP_MOV_A_HLB: begin
				gpr.we[`CTD_IDX_A]    = exec;
				gpr.wdata[`CTD_IDX_A] = md;
			end
			OP_MOV_ABS_A, OP_MOV_HLB_A: next_mem_we = exec;
			OP_MOV_PSW_IMM: next_psw = opnd_lo;
			OP_MOV_PSW_A: next_psw = acc;
			OP_MOV_A_PSW: begin
				gpr.we[`CTD_IDX_A]    = exec;
				gpr.wdata[`CTD_IDX_A] = status_word;
			end
			OP_XCH_A_R: begin
				gpr.we[`CTD_IDX_A]    = exec;
				gpr.we[sel_r]         = exec;
				gpr.wdata[`CTD_IDX_A] = gpr.rdata[sel_r];
				gpr.wdata[sel_r]      = acc;
			end
			OP_XCH_A_HLB: begin
				gpr.we[`CTD_IDX_A]    = exec;
				gpr.wdata[`CTD_IDX_A] = md;
				next_mem_we           = exec;
			end
			OP_TRANSFER_WORD_AX_RP: begin
				gpr.we[1:0]    = {2{exec}};
				gpr.wdata[1:0] = {gpr.rdata[sel_hi], gpr.rdata[sel_lo]};
			end
			OP_TRANSFER_WORD_RP_AX: begin
				gpr.we[sel_lo]    = exec;
				gpr.we[sel_hi]    = exec;
				gpr.wdata[sel_lo] = gpr.rdata[0];
				gpr.wdata[sel_hi] = gpr.rdata[1];
			end
			OP_SWAP_WORD: begin
				gpr.we[1:0]       = {2{exec}};
				gpr.we[sel_lo]    = exec;
				gpr.we[sel_hi]    = exec;
				gpr.wdata[1:0]    = {gpr.rdata[sel_hi], gpr.rdata[sel_lo]};
				gpr.wdata[sel_lo] = gpr.rdata[0];
				gpr.wdata[sel_hi] = gpr.rdata[1];
			end
			OP_ADD_SADDR_IMM: begin
				next_mem_we    = exec;
				next_mem_wdata = alu_res;
			end
			OP_BR_REL: next_pc = pc_step + br_off;
			default: begin
				gpr.we[`CTD_IDX_A]    = exec & is_arith;
				gpr.wdata[`CTD_IDX_A] = alu_res;
			end
		endcase
		if (is_arith | (op == OP_ADD_SADDR_IMM)) begin
			next_psw[`CTD_PSW_CY] = alu_cy;
			next_psw[`CTD_PSW_AC] = alu_ac;
			next_psw[`CTD_PSW_Z]  = (alu_res == 8'h00);
		end
	end

	// cpu clock from the select register
	wire [2:0] div_top = ~(3'b111 << cpu_clock_select_reg);
	wire       tick    = (div_cnt == div_top);

	// sequencer
	ctd_state_e next_state;
	always_comb begin
		case (state)
			ST_IDLE:    next_state = (start_req & ~bad_form)
			                         ? (needs_rd ? ST_RD_REQ : ST_EXEC) : ST_IDLE;
			ST_RD_REQ:  next_state = ST_RD_DATA;
			ST_RD_DATA: next_state = ST_EXEC;
			ST_EXEC:    next_state = ST_HOLD;
			ST_HOLD:    next_state = (tick & (tick_cnt == tm.clocks - 4'h1))
			                         ? ST_IDLE : ST_HOLD;
			default:    next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req & ~wb_ack_o;
			wb_dat_o <= rd_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= ST_IDLE;
			div_cnt  <= 3'h0;
			tick_cnt <= 4'h0;
		end else begin
			state    <= next_state;
			div_cnt  <= tick ? 3'h0 : div_cnt + 3'h1;
			tick_cnt <= idle ? 4'h0 : tick_cnt + {3'h0, tick};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op    <= OP_MOV_R_IMM;
			instr <= 24'h00_0000;
			bad   <= 1'b0;
		end else begin
			if (start_req) begin
				op  <= op_dec;
				bad <= bad_form;
			end
			if (wr_instr)
				instr <= wb_merged_instr[23:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_word          <= `CTD_PSW_RST;
			pc                   <= `CTD_PC_RST;
			cpu_clock_select_reg <= `CTD_CLKSEL_RST;
		end else begin
			if (exec) begin
				status_word <= next_psw;
				pc          <= next_pc;
			end else if (wr_psw)
				status_word <= wb_dat_i[7:0];
			else if (wr_pc)
				pc <= pc_merged[15:0];
			if (wr_clksel)
				cpu_clock_select_reg <= wb_dat_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_addr_o  <= 16'h0000;
			mem_wdata_o <= 8'h00;
			mem_re_o    <= 1'b0;
			mem_we_o    <= 1'b0;
			md          <= 8'h00;
		end else begin
			if (idle & start_req & ~bad_form)
				mem_addr_o <= next_addr;
			mem_re_o    <= idle & start_req & ~bad_form & needs_rd;
			mem_we_o    <= next_mem_we;
			mem_wdata_o <= next_mem_wdata;
			if (state == ST_RD_DATA)
				md <= mem_rdata_i;
		end
	end
endmodule

// ### ctd_core_properties.sv
// bus and memory strobe properties of the datapath top
`timescale 1ns/1ps
module ctd_core_properties (
	// clock and reset
	input wire logic               clk_i,
	input wire logic               rst_i,
	// wishbone
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [7:0]         wb_adr_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	// memory port
	input wire ctd_pkg::ctd_word_t mem_addr_o,
	input wire logic               mem_re_o,
	input wire logic               mem_we_o
);
	import ctd_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_answer;
		##1 wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_one_late: assert property (s_req |-> s_answer)
		else $error("ack not one cycle after request");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
		&& wb_adr_i > 8'h18 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_read_pulse: assert property (mem_re_o |=> !mem_re_o)
		else $error("read strobe longer than one cycle");
	a_write_pulse: assert property (mem_we_o |=> !mem_we_o)
		else $error("write strobe longer than one cycle");
	a_rw_apart: assert property (!(mem_re_o && mem_we_o))
		else $error("read and write strobe together");
	a_addr_hold: assert property (mem_re_o |=> $stable(mem_addr_o) [*3])
		else $error("memory address moved during access");
	a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !mem_re_o
		&& !mem_we_o && mem_addr_o == 16'h0000)
		else $error("outputs not cleared by reset");
endmodule
bind ctd_core ctd_core_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o));

// ### ctd_mem_model.sv
// byte memory with one-cycle read latency
`timescale 1ns/1ps
module ctd_mem_model (
	// clock
	input  wire logic               clk_i,
	// memory port
	input  wire ctd_pkg::ctd_word_t addr_i,
	input  wire ctd_pkg::ctd_byte_t wdata_i,
	input  wire logic               re_i,
	input  wire logic               we_i,
	output ctd_pkg::ctd_byte_t      rdata_o
);
	import ctd_pkg::*;
	ctd_byte_t mem [0:65535];
	initial rdata_o = 8'hA5;
	// data valid only in the cycle after a read strobe, garbage otherwise
	always @(posedge clk_i) begin
		if (we_i)
			mem[addr_i] <= wdata_i;
		rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
	end
endmodule

// ### tb.sv
// self-checking bench for the datapath through its register bus
`timescale 1ns/1ps
module tb;
	import ctd_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	ctd_word_t   mem_addr_o;
	ctd_byte_t   mem_wdata_o;
	logic        mem_re_o;
	logic        mem_we_o;
	ctd_byte_t   mem_rdata_i;
	int          fails;
	int          n_tests;
	logic [31:0] q;
	logic [31:0] pc0;
	logic [7:0]  vals [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h10, 8'h80};

	ctd_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
		.mem_rdata_i(mem_rdata_i));
	ctd_mem_model mem_u (.clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
		.re_i(mem_re_o), .we_i(mem_we_o), .rdata_o(mem_rdata_i));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// load, start, expect busy (or bad), wait for idle
	task automatic run(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi,
		input logic bad);
		int n;
		wb(1'b1, 8'h04, {8'h00, hi, lo, op});
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b0, 8'h00, 32'h0);
		chk({30'h0, q[1:0]}, {30'h0, bad, !bad});
		n = 0;
		while (q[0] !== 1'b0 && n < 40) begin
			wb(1'b0, 8'h00, 32'h0);
			n++;
		end
		chk({30'h0, q[1:0]}, {30'h0, bad, 1'b0});
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		close_out();
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		fails = 0;
		n_tests = 0;
		mem_u.mem[16'h1234] = 8'hDE;
		mem_u.mem[16'h8010] = 8'h7E;
		mem_u.mem[16'h8016] = 8'h3C;
		mem_u.mem[16'h8017] = 8'h3D;
		mem_u.mem[16'hFF10] = 8'h01;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h08, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h40, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
			run(8'h00, i[7:0], vals[i], 1'b0);
		rd(8'h14, 32'h44332211);
		rd(8'h18, 32'h80106655);
		rd(8'h0C, 32'h18);
		$display("test load done");
		run(8'h10, 8'h34, 8'h12, 1'b0);
		rd(8'h14, 32'h44330011);
		rd(8'h08, 32'h51);
		run(8'h12, 8'h0F, 8'h00, 1'b0);
		rd(8'h14, 32'h44331011);
		rd(8'h08, 32'h10);
		run(8'h05, 8'h81, 8'h00, 1'b0);
		run(8'h06, 8'h00, 8'h00, 1'b0);
		rd(8'h14, 32'h44338111);
		rd(8'h08, 32'h81);
		run(8'h13, 8'h00, 8'h00, 1'b0);
		rd(8'h14, 32'h44330011);
		rd(8'h08, 32'hD1);
		$display("test add done");
		run(8'h00, 8'h01, 8'h5A, 1'b0);
		run(8'h09, 8'h05, 8'h00, 1'b0);
		chk({24'h0, mem_u.mem[16'h8015]}, 32'h5A);
		run(8'h0B, 8'h06, 8'h00, 1'b0);
		chk({24'h0, mem_u.mem[16'h8016]}, 32'h5A);
		rd(8'h14, 32'h44333C11);
		rd(8'h08, 32'hD1);
		$display("test memory transfer done");
		run(8'h14, 8'h07, 8'h00, 1'b0);
		rd(8'h14, 32'h4433FF11);
		rd(8'h08, 32'h91);
		run(8'h11, 8'h10, 8'h02, 1'b0);
		chk({24'h0, mem_u.mem[16'hFF10]}, 32'h03);
		rd(8'h08, 32'h80);
		$display("test subtract and short direct done");
		run(8'h0C, 8'h03, 8'h00, 1'b0);
		rd(8'h14, 32'h44338010);
		run(8'h0E, 8'h01, 8'h00, 1'b0);
		rd(8'h14, 32'h80104433);
		wb(1'b0, 8'h0C, 32'h0);
		pc0 = q;
		run(8'h0C, 8'h00, 8'h00, 1'b1);
		run(8'h0E, 8'h00, 8'h00, 1'b1);
		run(8'h01, 8'h01, 8'h00, 1'b1);
		run(8'h17, 8'h00, 8'h00, 1'b1);
		rd(8'h0C, pc0);
		rd(8'h14, 32'h80104433);
		run(8'h16, 8'hFC, 8'h00, 1'b0);
		rd(8'h0C, pc0 - 32'h2);
		$display("test word and refusal done");
		wb(1'b1, 8'h10, 32'h3);
		rd(8'h10, 32'h3);
		run(8'h0F, 8'h0C, 8'h00, 1'b0);
		rd(8'h14, 32'h80105033);
		rd(8'h08, 32'h90);
		$display("test slow clock done");
		wb(1'b1, 8'h10, 32'h0);
		rd(8'h10, 32'h0);
		wb(1'b1, 8'h0C, 32'h0100);
		wb(1'b1, 8'h08, 32'h01);
		rd(8'h08, 32'h01);
		run(8'h15, 8'h50, 8'h00, 1'b0);
		rd(8'h14, 32'h80100033);
		rd(8'h08, 32'h40);
		run(8'h02, 8'h04, 8'h00, 1'b0);
		run(8'h0A, 8'h05, 8'h00, 1'b0);
		rd(8'h14, 32'h80106633);
		rd(8'h18, 32'h80100000);
		rd(8'h08, 32'h40);
		run(8'h04, 8'h00, 8'h90, 1'b0);
		chk({24'h0, mem_u.mem[16'h9000]}, 32'h66);
		run(8'h03, 8'h34, 8'h12, 1'b0);
		rd(8'h14, 32'h8010DE33);
		run(8'h08, 8'h05, 8'h00, 1'b0);
		rd(8'h14, 32'h80105A33);
		rd(8'h08, 32'h40);
		run(8'h07, 8'h00, 8'h00, 1'b0);
		rd(8'h08, 32'h5A);
		run(8'h0D, 8'h02, 8'h00, 1'b0);
		rd(8'h18, 32'h80105A33);
		rd(8'h08, 32'h5A);
		rd(8'h0C, 32'h0111);
		$display("test remaining forms done");
		close_out();
	end
endmodule
